// file: design/pbr_pkg.sv
package pbr_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_POWER_CONTROL  = 8'h00;
  localparam logic [7:0] OFF_SCRATCH_A      = 8'h01;
  localparam logic [7:0] OFF_SCRATCH_B      = 8'h02;
  localparam logic [7:0] OFF_SCRATCH_C      = 8'h03;
  localparam logic [7:0] OFF_SCRATCH_D      = 8'h04;
  localparam logic [7:0] OFF_BUCK_A_VOLTAGE = 8'h05;
  localparam logic [7:0] OFF_BUCK_A_MODE    = 8'h06;
  localparam logic [7:0] OFF_BUCK_A_CONFIG  = 8'h07;
  localparam logic [7:0] OFF_BUCK_B_VOLTAGE = 8'h08;
  localparam logic [7:0] OFF_BUCK_B_MODE    = 8'h09;
  localparam logic [7:0] OFF_BUCK_B_CONFIG  = 8'h0A;
  localparam logic [7:0] OFF_BUCK_C_VOLTAGE = 8'h0B;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int unsigned BIT_LDO_PROTECT    = 7;
  localparam int unsigned BIT_LONG_PRESS_OFF = 1;
  localparam int unsigned BIT_AUTO_RESTART   = 0;
  localparam int unsigned VOLT_MSB           = 4;
  localparam int unsigned MODE_MSB           = 3;
  localparam int unsigned PHASE_MSB          = 5;
  localparam int unsigned PHASE_LSB          = 4;
  localparam int unsigned FREQ_MSB           = 3;
  localparam int unsigned FREQ_LSB           = 2;
  localparam int unsigned BIT_ILIM           = 0;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_POWER_CONTROL = 8'h00;
  localparam logic [7:0] RST_SCRATCH       = 8'h00;
  localparam logic [7:0] RST_BUCK_FIELDS   = 8'h00;

  // ----------------------------------------------------------------
  // timing and LDO count
  // ----------------------------------------------------------------
  localparam int unsigned CLK_FREQ_HZ     = 100_000_000;
  localparam int unsigned LONG_PRESS_MS   = 4000;
  localparam int unsigned HOLD_CYCLES     =
    LONG_PRESS_MS * (CLK_FREQ_HZ / 1000);
  localparam int unsigned LDO_COUNT       = 4;

endpackage

// file: design/pbr_press_timer.sv
`timescale 1ns/100ps
`default_nettype none

module pbr_press_timer #(
  parameter int unsigned HOLD_CYCLES = pbr_pkg::HOLD_CYCLES
) (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic arst_n,
  // press level, already synchronised
  input  wire logic held_low,
  // one pulse per press that lasts long enough
  output var  logic fired
);

  localparam int unsigned CW = $clog2(HOLD_CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(HOLD_CYCLES - 1);
  localparam logic [CW-1:0] FULL = CW'(HOLD_CYCLES);

  logic [CW-1:0] count;

  // saturates so a press held beyond the limit fires only once
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      count <= '0;
    end else if (!held_low) begin
      count <= '0;
    end else if (count != FULL) begin
      count <= count + CW'(1);
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      fired <= 1'b0;
    end else begin
      fired <= held_low && (count == LAST);
    end
  end

endmodule

`default_nettype wire

// file: design/pbr_regs.sv
`timescale 1ns/100ps
`default_nettype none

// What this block does
// - protection bit shuts down current-limited LDOs
// - long press enters off when enabled
// - auto restart after long-press off if configured
// - four full-byte scratch registers survive battery loss
// - scratch cleared only by backup cell reset
// - buck voltage registers hold 5-bit codes
// - buck mode registers hold 4-bit selectors
// - config bits 5:4 select phase
// - config bits 3:2 select frequency
// - config bit 0 selects current limit
// - buck registers accessible at any time
// - buck A voltage, configs load from OTP
// - other buck registers load start-up values
module pbr_regs #(
  parameter int unsigned HOLD_CYCLES = pbr_pkg::HOLD_CYCLES
) (
  // clock and resets
  input  wire logic       sys_clk,
  input  wire logic       arst_n,
  input  wire logic       backup_cell_power_on_reset_n,
  // register access port
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output var  logic [7:0] reg_rdata,
  // reset-time values from otp and start-up sequencer
  input  wire logic [4:0] otp_buck_a_voltage,
  input  wire logic [7:0] otp_buck_a_config,
  input  wire logic [7:0] otp_buck_b_config,
  input  wire logic [3:0] startup_buck_a_mode,
  input  wire logic [3:0] startup_buck_b_mode,
  input  wire logic [4:0] startup_buck_b_voltage,
  input  wire logic [4:0] startup_buck_c_voltage,
  // pins and analog status
  input  wire logic       power_button_pin_n,
  input  wire logic       power_config_select,
  input  wire logic [3:0] ldo_current_limit,
  // power control
  output var  logic       ldo_short_protect_enable,
  output var  logic       long_press_off_enable,
  output var  logic       auto_restart_enable,
  output var  logic [3:0] ldo_shutdown,
  output var  logic       off_request,
  output var  logic       restart_request,
  // buck settings
  output var  logic [4:0] buck_a_voltage_code,
  output var  logic [3:0] buck_a_mode_select,
  output var  logic [1:0] buck_a_phase_select,
  output var  logic [1:0] buck_a_freq_select,
  output var  logic       buck_a_current_limit_select,
  output var  logic [4:0] buck_b_voltage_code,
  output var  logic [3:0] buck_b_mode_select,
  output var  logic [1:0] buck_b_phase_select,
  output var  logic [1:0] buck_b_freq_select,
  output var  logic       buck_b_current_limit_select,
  output var  logic [4:0] buck_c_voltage_code
);

  logic [7:0] scratch_byte_a;
  logic [7:0] scratch_byte_b;
  logic [7:0] scratch_byte_c;
  logic [7:0] scratch_byte_d;
  logic       init_pending;
  logic [5:0] sync_a;
  logic [5:0] sync_b;
  logic       press_fired;
  logic [7:0] next_rdata;
  logic [4:0] wdata_volt;

  assign wdata_volt = reg_wdata[pbr_pkg::VOLT_MSB:0];

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  // {ldo limits, config strap, inverted button}; stage a feeds b only
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      sync_a <= 6'h00;
      sync_b <= 6'h00;
    end else begin
      sync_a <= {ldo_current_limit, power_config_select,
                 ~power_button_pin_n};
      sync_b <= sync_a;
    end
  end

  // ----------------------------------------------------------------
  // power control register
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ldo_short_protect_enable <=
        pbr_pkg::RST_POWER_CONTROL[pbr_pkg::BIT_LDO_PROTECT];
      long_press_off_enable <=
        pbr_pkg::RST_POWER_CONTROL[pbr_pkg::BIT_LONG_PRESS_OFF];
      auto_restart_enable <=
        pbr_pkg::RST_POWER_CONTROL[pbr_pkg::BIT_AUTO_RESTART];
    end else if (reg_wr && reg_addr == pbr_pkg::OFF_POWER_CONTROL) begin
      ldo_short_protect_enable <= reg_wdata[pbr_pkg::BIT_LDO_PROTECT];
      long_press_off_enable <= reg_wdata[pbr_pkg::BIT_LONG_PRESS_OFF];
      auto_restart_enable <= reg_wdata[pbr_pkg::BIT_AUTO_RESTART];
    end
  end

  // latched so a regulator does not bounce back on once the limit clears
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ldo_shutdown <= 4'h0;
    end else if (!ldo_short_protect_enable) begin
      ldo_shutdown <= 4'h0;
    end else begin
      ldo_shutdown <= ldo_shutdown | sync_b[5:2];
    end
  end

  // ----------------------------------------------------------------
  // long press and restart
  // ----------------------------------------------------------------
  pbr_press_timer #(
    .HOLD_CYCLES (HOLD_CYCLES)
  ) u_press (
    .sys_clk  (sys_clk),
    .arst_n   (arst_n),
    .held_low (sync_b[0]),
    .fired    (press_fired)
  );

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      off_request     <= 1'b0;
      restart_request <= 1'b0;
    end else begin
      off_request     <= press_fired && long_press_off_enable;
      restart_request <= off_request && auto_restart_enable
                         && sync_b[1];
    end
  end

  // ----------------------------------------------------------------
  // scratch memory
  // ----------------------------------------------------------------
  // only the backup cell reset clears these, main reset leaves them
  always_ff @(posedge sys_clk or negedge backup_cell_power_on_reset_n) begin
    if (!backup_cell_power_on_reset_n) begin
      scratch_byte_a <= pbr_pkg::RST_SCRATCH;
      scratch_byte_b <= pbr_pkg::RST_SCRATCH;
      scratch_byte_c <= pbr_pkg::RST_SCRATCH;
      scratch_byte_d <= pbr_pkg::RST_SCRATCH;
    end else if (reg_wr) begin
      if (reg_addr == pbr_pkg::OFF_SCRATCH_A) begin
        scratch_byte_a <= reg_wdata;
      end else if (reg_addr == pbr_pkg::OFF_SCRATCH_B) begin
        scratch_byte_b <= reg_wdata;
      end else if (reg_addr == pbr_pkg::OFF_SCRATCH_C) begin
        scratch_byte_c <= reg_wdata;
      end else if (reg_addr == pbr_pkg::OFF_SCRATCH_D) begin
        scratch_byte_d <= reg_wdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // buck registers
  // ----------------------------------------------------------------
  // async reset may only load constants, so otp and start-up values
  // are taken at the first edge after release
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      init_pending <= 1'b1;
    end else begin
      init_pending <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      buck_a_voltage_code <= pbr_pkg::RST_BUCK_FIELDS[4:0];
      buck_a_mode_select  <= pbr_pkg::RST_BUCK_FIELDS[3:0];
      buck_b_voltage_code <= pbr_pkg::RST_BUCK_FIELDS[4:0];
      buck_b_mode_select  <= pbr_pkg::RST_BUCK_FIELDS[3:0];
      buck_c_voltage_code <= pbr_pkg::RST_BUCK_FIELDS[4:0];
    end else if (reg_wr) begin
      if (reg_addr == pbr_pkg::OFF_BUCK_A_VOLTAGE) begin
        buck_a_voltage_code <= wdata_volt;
      end else if (reg_addr == pbr_pkg::OFF_BUCK_A_MODE) begin
        buck_a_mode_select <= reg_wdata[pbr_pkg::MODE_MSB:0];
      end else if (reg_addr == pbr_pkg::OFF_BUCK_B_VOLTAGE) begin
        buck_b_voltage_code <= wdata_volt;
      end else if (reg_addr == pbr_pkg::OFF_BUCK_B_MODE) begin
        buck_b_mode_select <= reg_wdata[pbr_pkg::MODE_MSB:0];
      end else if (reg_addr == pbr_pkg::OFF_BUCK_C_VOLTAGE) begin
        buck_c_voltage_code <= wdata_volt;
      end
    end else if (init_pending) begin
      buck_a_voltage_code <= otp_buck_a_voltage;
      buck_a_mode_select  <= startup_buck_a_mode;
      buck_b_voltage_code <= startup_buck_b_voltage;
      buck_b_mode_select  <= startup_buck_b_mode;
      buck_c_voltage_code <= startup_buck_c_voltage;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      buck_a_phase_select <= pbr_pkg::RST_BUCK_FIELDS[1:0];
      buck_a_freq_select  <= pbr_pkg::RST_BUCK_FIELDS[1:0];
      buck_a_current_limit_select <= pbr_pkg::RST_BUCK_FIELDS[0];
      buck_b_phase_select <= pbr_pkg::RST_BUCK_FIELDS[1:0];
      buck_b_freq_select  <= pbr_pkg::RST_BUCK_FIELDS[1:0];
      buck_b_current_limit_select <= pbr_pkg::RST_BUCK_FIELDS[0];
    end else if (reg_wr && reg_addr == pbr_pkg::OFF_BUCK_A_CONFIG) begin
      buck_a_phase_select <=
        reg_wdata[pbr_pkg::PHASE_MSB:pbr_pkg::PHASE_LSB];
      buck_a_freq_select <=
        reg_wdata[pbr_pkg::FREQ_MSB:pbr_pkg::FREQ_LSB];
      buck_a_current_limit_select <= reg_wdata[pbr_pkg::BIT_ILIM];
    end else if (reg_wr && reg_addr == pbr_pkg::OFF_BUCK_B_CONFIG) begin
      buck_b_phase_select <=
        reg_wdata[pbr_pkg::PHASE_MSB:pbr_pkg::PHASE_LSB];
      buck_b_freq_select <=
        reg_wdata[pbr_pkg::FREQ_MSB:pbr_pkg::FREQ_LSB];
      buck_b_current_limit_select <= reg_wdata[pbr_pkg::BIT_ILIM];
    end else if (init_pending) begin
      buck_a_phase_select <=
        otp_buck_a_config[pbr_pkg::PHASE_MSB:pbr_pkg::PHASE_LSB];
      buck_a_freq_select <=
        otp_buck_a_config[pbr_pkg::FREQ_MSB:pbr_pkg::FREQ_LSB];
      buck_a_current_limit_select <= otp_buck_a_config[pbr_pkg::BIT_ILIM];
      buck_b_phase_select <=
        otp_buck_b_config[pbr_pkg::PHASE_MSB:pbr_pkg::PHASE_LSB];
      buck_b_freq_select <=
        otp_buck_b_config[pbr_pkg::FREQ_MSB:pbr_pkg::FREQ_LSB];
      buck_b_current_limit_select <= otp_buck_b_config[pbr_pkg::BIT_ILIM];
    end
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  always_comb begin
    next_rdata = 8'h00;
    if (reg_addr == pbr_pkg::OFF_POWER_CONTROL) begin
      next_rdata[pbr_pkg::BIT_LDO_PROTECT] = ldo_short_protect_enable;
      next_rdata[pbr_pkg::BIT_LONG_PRESS_OFF] = long_press_off_enable;
      next_rdata[pbr_pkg::BIT_AUTO_RESTART] = auto_restart_enable;
    end else if (reg_addr == pbr_pkg::OFF_SCRATCH_A) begin
      next_rdata = scratch_byte_a;
    end else if (reg_addr == pbr_pkg::OFF_SCRATCH_B) begin
      next_rdata = scratch_byte_b;
    end else if (reg_addr == pbr_pkg::OFF_SCRATCH_C) begin
      next_rdata = scratch_byte_c;
    end else if (reg_addr == pbr_pkg::OFF_SCRATCH_D) begin
      next_rdata = scratch_byte_d;
    end else if (reg_addr == pbr_pkg::OFF_BUCK_A_VOLTAGE) begin
      next_rdata[4:0] = buck_a_voltage_code;
    end else if (reg_addr == pbr_pkg::OFF_BUCK_A_MODE) begin
      next_rdata[3:0] = buck_a_mode_select;
    end else if (reg_addr == pbr_pkg::OFF_BUCK_A_CONFIG) begin
      next_rdata[5:2] = {buck_a_phase_select, buck_a_freq_select};
      next_rdata[0] = buck_a_current_limit_select;
    end else if (reg_addr == pbr_pkg::OFF_BUCK_B_VOLTAGE) begin
      next_rdata[4:0] = buck_b_voltage_code;
    end else if (reg_addr == pbr_pkg::OFF_BUCK_B_MODE) begin
      next_rdata[3:0] = buck_b_mode_select;
    end else if (reg_addr == pbr_pkg::OFF_BUCK_B_CONFIG) begin
      next_rdata[5:2] = {buck_b_phase_select, buck_b_freq_select};
      next_rdata[0] = buck_b_current_limit_select;
    end else if (reg_addr == pbr_pkg::OFF_BUCK_C_VOLTAGE) begin
      next_rdata[4:0] = buck_c_voltage_code;
    end
  end

  // no wait state: reads never stall on regulator state
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  a_unmapped_reads_zero: assert property (
    reg_rd && reg_addr > pbr_pkg::OFF_BUCK_C_VOLTAGE |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_mode_upper_zero: assert property (
    reg_rd && reg_addr == pbr_pkg::OFF_BUCK_A_MODE |=> reg_rdata[7:4] == 4'h0)
    else $error("mode reserved bits not zero");
  a_volt_write_taken: assert property (
    reg_wr && reg_addr == pbr_pkg::OFF_BUCK_A_VOLTAGE
    |=> buck_a_voltage_code == $past(wdata_volt))
    else $error("buck a voltage write lost");
  a_ldo_shutdown_set: assert property (
    ldo_short_protect_enable && sync_b[2] && !reg_wr |=> ldo_shutdown[0])
    else $error("ldo not shut down on limit");
  a_ldo_no_shutdown: assert property (
    !ldo_short_protect_enable |=> ldo_shutdown == 4'h0)
    else $error("ldo shut down while protection off");
  a_off_needs_enable: assert property (
    off_request |-> $past(long_press_off_enable) && $past(press_fired))
    else $error("off request without enable");
  a_restart_after_off: assert property (
    restart_request |-> $past(off_request) && $past(auto_restart_enable))
    else $error("restart without off event");
  a_startup_load: assert property (
    init_pending && !reg_wr
    |=> buck_b_voltage_code == $past(startup_buck_b_voltage))
    else $error("start-up voltage not loaded");
  a_read_next_cycle: assert property (
    reg_rd && reg_addr == pbr_pkg::OFF_POWER_CONTROL
    |=> reg_rdata[pbr_pkg::BIT_AUTO_RESTART] == $past(auto_restart_enable))
    else $error("power control read wrong");

  c_long_press_off: cover property (off_request);
  c_auto_restart: cover property (off_request ##1 restart_request);
  c_ldo_shutdown: cover property ($rose(ldo_shutdown[0]));
  c_scratch_write: cover property (
    reg_wr && reg_addr == pbr_pkg::OFF_SCRATCH_D);

endmodule

`default_nettype wire

// file: tb/pbr_tb.sv
`timescale 1ns/100ps
`default_nettype none

module tb;
  localparam int unsigned HOLD = 20;

  logic       sys_clk;
  logic       arst_n;
  logic       bkp_rst_n;
  logic       reg_wr;
  logic       reg_rd;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic       button_n;
  logic       cfg_sel;
  logic [3:0] ldo_limit;
  logic [4:0] otp_a_volt;
  logic [4:0] su_c_volt;
  logic       prot_en;
  logic       lp_en;
  logic       ar_en;
  logic [3:0] ldo_shutdown;
  logic       off_request;
  logic       restart_request;
  logic [4:0] a_volt;
  logic [3:0] a_mode;
  logic [1:0] a_phase;
  logic [1:0] a_freq;
  logic       a_ilim;
  logic [4:0] b_volt;
  logic [3:0] b_mode;
  logic [1:0] b_phase;
  logic [1:0] b_freq;
  logic       b_ilim;
  logic [4:0] c_volt;
  logic [7:0] rd_val;
  logic [7:0] pats [3];
  int unsigned n_errors;
  int unsigned samples_checked;
  // implemented bits per offset 00..0B, unmapped 0C
  logic [7:0] mask [13] = '{8'h83, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h1F,
                            8'h0F, 8'h3D, 8'h1F, 8'h0F, 8'h3D, 8'h1F, 8'h00};
  // reset image from the otp and start-up values driven below
  logic [7:0] rst_exp [12] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h15,
                               8'h09, 8'h3D, 8'h0A, 8'h06, 8'h24, 8'h1B};

  pbr_regs #(.HOLD_CYCLES(HOLD)) dut_u (
    .sys_clk                      (sys_clk),
    .arst_n                       (arst_n),
    .backup_cell_power_on_reset_n (bkp_rst_n),
    .reg_wr                       (reg_wr),
    .reg_rd                       (reg_rd),
    .reg_addr                     (reg_addr),
    .reg_wdata                    (reg_wdata),
    .reg_rdata                    (reg_rdata),
    .otp_buck_a_voltage           (otp_a_volt),
    .otp_buck_a_config            (8'hFF),
    .otp_buck_b_config            (8'h26),
    .startup_buck_a_mode          (4'h9),
    .startup_buck_b_mode          (4'h6),
    .startup_buck_b_voltage       (5'h0A),
    .startup_buck_c_voltage       (su_c_volt),
    .power_button_pin_n           (button_n),
    .power_config_select          (cfg_sel),
    .ldo_current_limit            (ldo_limit),
    .ldo_short_protect_enable     (prot_en),
    .long_press_off_enable        (lp_en),
    .auto_restart_enable          (ar_en),
    .ldo_shutdown                 (ldo_shutdown),
    .off_request                  (off_request),
    .restart_request              (restart_request),
    .buck_a_voltage_code          (a_volt),
    .buck_a_mode_select           (a_mode),
    .buck_a_phase_select          (a_phase),
    .buck_a_freq_select           (a_freq),
    .buck_a_current_limit_select  (a_ilim),
    .buck_b_voltage_code          (b_volt),
    .buck_b_mode_select           (b_mode),
    .buck_b_phase_select          (b_phase),
    .buck_b_freq_select           (b_freq),
    .buck_b_current_limit_select  (b_ilim),
    .buck_c_voltage_code          (c_volt)
  );

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // ----------------------------------------------------------------
  // access and check tasks
  // ----------------------------------------------------------------
  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] got, input logic [7:0] exp,
                       input string what);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
  endtask

  // data lands on the edge that takes the strobe; sample just after it
  task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd   <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  task automatic read_all(input logic [7:0] fill, input logic all_fill);
    for (int i = 0; i < 12; i++) begin
      reg_read(8'(i), rd_val);
      check(rd_val, all_fill ? (fill & mask[i]) : rst_exp[i],
            "readback");
    end
  endtask

  // hold the button low past the count and log the pulses seen
  task automatic press(input int exp_off, input int exp_rs);
    int n_off;
    int n_rs;
    int off_at;
    int rs_at;
    n_off  = 0;
    n_rs   = 0;
    off_at = 0;
    rs_at  = 0;
    @(posedge sys_clk);
    button_n <= 1'b0;
    for (int c = 0; c < HOLD + 40; c++) begin
      @(posedge sys_clk);
      #1;
      if (off_request === 1'b1) begin
        n_off++;
        off_at = c;
      end
      if (restart_request === 1'b1) begin
        n_rs++;
        rs_at = c;
      end
    end
    @(posedge sys_clk);
    button_n <= 1'b1;
    check(8'(n_off), 8'(exp_off), "off pulses");
    check(8'(n_rs), 8'(exp_rs), "restart pulses");
    if (exp_off == 1) begin
      check(8'(off_at >= HOLD), 8'h01, "off too early");
    end
    if (exp_rs == 1) begin
      check(8'(rs_at - off_at), 8'h01, "restart spacing");
    end
    repeat (6) @(posedge sys_clk);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    n_errors = 0;
    samples_checked = 0;
    arst_n = 1'b0;
    bkp_rst_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    button_n = 1'b1;
    cfg_sel = 1'b1;
    ldo_limit = 4'h0;
    otp_a_volt = 5'h15;
    su_c_volt = 5'h1B;
    pats = '{8'hFF, 8'h96, 8'h69};
    repeat (12) @(posedge sys_clk);
    arst_n <= 1'b1;
    bkp_rst_n <= 1'b1;
    repeat (2) @(posedge sys_clk);

    read_all(8'h00, 1'b0);
    $display("test reset_values done");

    // writes with an idle cycle between each, then readback and field outputs
    foreach (pats[p]) begin
      for (int i = 0; i <= 12; i++) begin
        reg_write(8'(i), pats[p]);
      end
      #1;
      check({3'h0, a_volt}, pats[p] & 8'h1F, "a volt");
      check({3'h0, b_volt}, pats[p] & 8'h1F, "b volt");
      check({3'h0, c_volt}, pats[p] & 8'h1F, "c volt");
      check({a_mode, b_mode}, {pats[p][3:0], pats[p][3:0]}, "mode");
      check({4'h0, a_phase, b_phase}, {4'h0, pats[p][5:4], pats[p][5:4]},
            "phase");
      check({4'h0, a_freq, b_freq}, {4'h0, pats[p][3:2], pats[p][3:2]},
            "freq");
      check({6'h0, a_ilim, b_ilim}, {6'h0, pats[p][0], pats[p][0]},
            "ilim");
      check({5'h0, prot_en, lp_en, ar_en}, {5'h0, pats[p][7], pats[p][1:0]},
            "power bits");
      read_all(pats[p], 1'b1);
      reg_read(8'h0C, rd_val);
      check(rd_val, 8'h00, "unmapped");
    end
    $display("test write_readback done");

    // main reset keeps the scratch bytes, backup reset clears them
    for (int i = 1; i <= 4; i++) reg_write(8'(i), 8'(8'hC0 + i));
    @(posedge sys_clk);
    arst_n <= 1'b0;
    otp_a_volt <= 5'h0E;
    su_c_volt <= 5'h11;
    repeat (3) @(posedge sys_clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge sys_clk);
    for (int i = 1; i <= 4; i++) begin
      reg_read(8'(i), rd_val);
      check(rd_val, 8'(8'hC0 + i), "scratch kept");
    end
    reg_read(8'h00, rd_val);
    check(rd_val, 8'h00, "power reset");
    reg_read(pbr_pkg::OFF_BUCK_A_VOLTAGE, rd_val);
    check(rd_val, 8'h0E, "otp reload");
    reg_read(pbr_pkg::OFF_BUCK_C_VOLTAGE, rd_val);
    check(rd_val, 8'h11, "start-up reload");
    @(posedge sys_clk);
    bkp_rst_n <= 1'b0;
    repeat (3) @(posedge sys_clk);
    bkp_rst_n <= 1'b1;
    repeat (2) @(posedge sys_clk);
    for (int i = 1; i <= 4; i++) begin
      reg_read(8'(i), rd_val);
      check(rd_val, 8'h00, "scratch cleared");
    end
    $display("test scratch_retention done");

    // long press with both enables off, off only, off plus restart, then off plus restart with the strap low
    press(0, 0);
    reg_write(8'h00, 8'h02);
    press(1, 0);
    reg_write(8'h00, 8'h03);
    press(1, 1);
    cfg_sel <= 1'b0;
    press(1, 0);
    cfg_sel <= 1'b1;
    $display("test long_press done");

    // ldo shutdown only while protection is enabled
    reg_write(8'h00, 8'h80);
    ldo_limit <= 4'b0101;
    repeat (10) @(posedge sys_clk);
    #1;
    check({4'h0, ldo_shutdown}, 8'h05, "ldo shutdown");
    @(posedge sys_clk);
    ldo_limit <= 4'b0000;
    repeat (6) @(posedge sys_clk);
    #1;
    check({4'h0, ldo_shutdown}, 8'h05, "ldo latched");
    reg_write(8'h00, 8'h00);
    ldo_limit <= 4'b1010;
    repeat (10) @(posedge sys_clk);
    #1;
    check({4'h0, ldo_shutdown}, 8'h00, "ldo unprotected");
    $display("test ldo_protect done");
    give_verdict();
  end
endmodule

`default_nettype wire
